// >>> design/amp_fault_pkg.sv
/*
  Shared constants for the amplifier fault status and recovery block: register
  addresses, field positions, reset values, recovery states and timing counts.
  Assumes a register clock of 100 MHz and that every user writes package::name.
*/
package amp_fault_pkg;

  // ----------------------------------------------------------------------
  // Register addresses and reset values.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_INFLECTION = 8'h09;
  localparam logic [7:0] ADDR_STATUS     = 8'h0A;
  localparam logic [7:0] ADDR_CONTROL    = 8'h0B;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_RESET   = 8'h18;
  localparam logic [7:0] INFLECTION_RESET = 8'h22;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // ----------------------------------------------------------------------
  // Status register bit positions.
  // ----------------------------------------------------------------------
  localparam int ST_RSVD = 7;
  localparam int ST_UV   = 6;
  localparam int ST_LIM  = 5;
  localparam int ST_CLIP = 4;
  localparam int ST_OC   = 3;
  localparam int ST_OTF  = 2;
  localparam int ST_OTW  = 1;
  localparam int ST_BAT  = 0;

  // ----------------------------------------------------------------------
  // Fault recovery control field positions.
  // ----------------------------------------------------------------------
  localparam int CT_ATTEN_HI = 7;
  localparam int CT_ATTEN_LO = 6;
  localparam int CT_TRIG     = 5;
  localparam int CT_LIMIT_HI = 4;
  localparam int CT_LIMIT_LO = 3;
  localparam int CT_SEL_UV   = 2;
  localparam int CT_SEL_OT   = 1;
  localparam int CT_SEL_OC   = 0;
  localparam logic [7:0] CONTROL_STORE_MASK = 8'hDF;
  localparam logic [1:0] LIMIT_UNLIMITED    = 2'h3;
  localparam logic [1:0] ATTEN_NONE         = 2'h0;

  // ----------------------------------------------------------------------
  // Condition vector layout and fault kinds (kinds line up with select bits).
  // ----------------------------------------------------------------------
  localparam int COND_W    = 6;
  localparam int COND_UV   = 0;
  localparam int COND_OC   = 1;
  localparam int COND_OTF  = 2;
  localparam int COND_OTW  = 3;
  localparam int COND_CLIP = 4;
  localparam int COND_LIM  = 5;
  localparam int KIND_W    = 3;
  localparam logic [KIND_W-1:0] KIND_NONE = 3'h0;

  // ----------------------------------------------------------------------
  // Attempt counting and recovery timing.
  // ----------------------------------------------------------------------
  localparam logic [2:0] ATTEMPTS_ONE   = 3'h1;
  localparam logic [2:0] ATTEMPTS_THREE = 3'h3;
  localparam logic [2:0] ATTEMPTS_SEVEN = 3'h7;
  localparam logic [2:0] COUNT_ZERO     = 3'h0;
  localparam logic [2:0] COUNT_STEP     = 3'h1;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RECOVERY_OK_NS  = 10000;
  localparam int RECOVERY_OK_CYC = (RECOVERY_OK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W         = 10;
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(RECOVERY_OK_CYC - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 10'h000;
  localparam logic [TIMER_W-1:0] TIMER_STEP = 10'h001;

  // Recovery states, Gray coded along run, fault, check, locked and back.
  typedef enum logic [1:0]
  {
    ST_RUN    = 2'b00,
    ST_FAULT  = 2'b01,
    ST_CHECK  = 2'b11,
    ST_LOCKED = 2'b10
  } rec_state_type;

  // Number of automatic attempts that a limit code allows.
  function automatic logic [2:0] attempts_allowed(input logic [1:0] code);
    logic [2:0] n;
    n = ATTEMPTS_SEVEN;
    unique case (code)
      2'h0: n = ATTEMPTS_ONE;
      2'h1: n = ATTEMPTS_THREE;
      2'h2: n = ATTEMPTS_SEVEN;
      2'h3: n = ATTEMPTS_SEVEN;
    endcase
    return n;
  endfunction

endpackage

// >>> design/cond_if.sv
/*
  Carrier for the cleaned analog fault and event conditions between the input
  conditioner and the register bank. Assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
interface cond_if;
  logic uv;    // Regulator undervoltage.
  logic oc;    // Output overcurrent.
  logic overheat_fault_flag;   // Overtemperature fault.
  logic overheat_warning_flag;   // Overtemperature warning.
  logic clip;  // Output clipping.
  logic lim;   // Limiter or tracking gain reduction active.

  modport src (output uv, oc, overheat_fault_flag, overheat_warning_flag, clip, lim);
  modport dst (input uv, oc, overheat_fault_flag, overheat_warning_flag, clip, lim);
endinterface

// >>> design/cond_sync.sv
/*
  Input conditioner: each analog condition passes three flip-flops and the clean
  value follows only when the second and third stages agree. Assumes the raw
  inputs are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module cond_sync
(
  input  wire logic                            sys_clk,        // Register clock.
  input  wire logic                            rst,            // Asynchronous reset, active high.
  input  wire logic [amp_fault_pkg::COND_W-1:0] raw_conditions, // Raw condition levels.
  cond_if.src                                  cond            // Cleaned conditions.
);

  logic [amp_fault_pkg::COND_W-1:0] ff1_r;
  logic [amp_fault_pkg::COND_W-1:0] ff2_r;
  logic [amp_fault_pkg::COND_W-1:0] ff3_r;
  logic [amp_fault_pkg::COND_W-1:0] clean_r;
  logic [amp_fault_pkg::COND_W-1:0] clean_nxt;
  logic [amp_fault_pkg::COND_W-1:0] disagree;

  // ----------------------------------------------------------------------
  // Filter: a short glitch that never reaches both late stages is dropped.
  // ----------------------------------------------------------------------
  always_comb
  begin
    disagree  = ff2_r ^ ff3_r;
    clean_nxt = (~disagree & ff2_r) | (disagree & clean_r);
  end

  // The first stage feeds only the second stage, to contain metastability.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ff1_r   <= '0;
      ff2_r   <= '0;
      ff3_r   <= '0;
      clean_r <= '0;
    end
    else
    begin
      ff1_r   <= raw_conditions;
      ff2_r   <= ff1_r;
      ff3_r   <= ff2_r;
      clean_r <= clean_nxt;
    end
  end

  // Cleaned levels onto the carrier.
  assign cond.uv   = clean_r[amp_fault_pkg::COND_UV];
  assign cond.oc   = clean_r[amp_fault_pkg::COND_OC];
  assign cond.overheat_fault_flag  = clean_r[amp_fault_pkg::COND_OTF];
  assign cond.overheat_warning_flag  = clean_r[amp_fault_pkg::COND_OTW];
  assign cond.clip = clean_r[amp_fault_pkg::COND_CLIP];
  assign cond.lim  = clean_r[amp_fault_pkg::COND_LIM];

endmodule

// >>> design/amp_fault_status_recovery.sv
/*
  Fault status and fault recovery register bank of a mono digital-input amplifier,
  with the recovery sequencer that gates the output stage.
  Assumes a register-access engine on sys_clk that gives one-cycle read and write
  strobes with address and data, and a battery code from same-clock logic.
*/
`timescale 1ns/1ps
module amp_fault_status_recovery
(
  input  wire logic       sys_clk,          // Register clock, 100 MHz.
  input  wire logic       rst,              // Asynchronous reset, active high.
  input  wire logic       uv_raw,           // Regulator undervoltage detector.
  input  wire logic       oc_raw,           // Output overcurrent detector.
  input  wire logic       otf_raw,          // Overtemperature fault detector.
  input  wire logic       otw_raw,          // Overtemperature warning detector.
  input  wire logic       clip_raw,         // Clip detector.
  input  wire logic       lim_raw,          // Limiter gain reduction active.
  input  wire logic [7:0] battery_code,     // Sensed battery code, same clock.
  input  wire logic [7:0] reg_addr,         // Register address.
  input  wire logic [7:0] reg_wdata,        // Write data.
  input  wire logic       reg_wr,           // Write strobe, one cycle.
  input  wire logic       reg_rd,           // Read strobe, one cycle.
  output logic      [7:0] reg_rdata,        // Read data, one cycle after strobe.
  output logic            amp_enable,       // Output stage enable.
  output logic      [1:0] thermal_warning_attenuation, // Active attenuation code.
  output logic      [7:0] supply_inflection_point      // Inflection value to limiter.
);

  cond_if cond ();

  logic [amp_fault_pkg::COND_W-1:0] raw_conditions;

  // ----------------------------------------------------------------------
  // Input conditioning.
  // ----------------------------------------------------------------------
  always_comb
  begin
    raw_conditions                          = '0;
    raw_conditions[amp_fault_pkg::COND_UV]   = uv_raw;
    raw_conditions[amp_fault_pkg::COND_OC]   = oc_raw;
    raw_conditions[amp_fault_pkg::COND_OTF]  = otf_raw;
    raw_conditions[amp_fault_pkg::COND_OTW]  = otw_raw;
    raw_conditions[amp_fault_pkg::COND_CLIP] = clip_raw;
    raw_conditions[amp_fault_pkg::COND_LIM]  = lim_raw;
  end

  cond_sync u_sync
  (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .raw_conditions (raw_conditions),
    .cond           (cond)
  );

  // ----------------------------------------------------------------------
  // Register file and status capture.
  // ----------------------------------------------------------------------
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] infl_r;
  logic [7:0] infl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       trig_r;
  logic       trig_nxt;
  logic [1:0] atten_r;
  logic [1:0] atten_nxt;
  logic       wr_ctrl;
  logic       wr_infl;
  logic [1:0] limit_code;
  logic [2:0] manual_sel;

  assign limit_code = ctrl_r[amp_fault_pkg::CT_LIMIT_HI:amp_fault_pkg::CT_LIMIT_LO];
  assign manual_sel = ctrl_r[amp_fault_pkg::CT_SEL_UV:amp_fault_pkg::CT_SEL_OC];

  // Status is sampled every cycle; the limiter flag also covers thermal attenuation.
  always_comb
  begin
    wr_ctrl    = reg_wr && (reg_addr == amp_fault_pkg::ADDR_CONTROL);
    wr_infl    = reg_wr && (reg_addr == amp_fault_pkg::ADDR_INFLECTION);
    status_nxt = amp_fault_pkg::STATUS_RESET;
    status_nxt[amp_fault_pkg::ST_UV]   = cond.uv;
    status_nxt[amp_fault_pkg::ST_LIM]  = cond.lim || (atten_r != amp_fault_pkg::ATTEN_NONE);
    status_nxt[amp_fault_pkg::ST_CLIP] = cond.clip;
    status_nxt[amp_fault_pkg::ST_OC]   = cond.oc;
    status_nxt[amp_fault_pkg::ST_OTF]  = cond.overheat_fault_flag;
    status_nxt[amp_fault_pkg::ST_OTW]  = cond.overheat_warning_flag;
    status_nxt[amp_fault_pkg::ST_BAT]  = (battery_code <= infl_r);
    ctrl_nxt   = wr_ctrl ? (reg_wdata & amp_fault_pkg::CONTROL_STORE_MASK) : ctrl_r;
    trig_nxt   = wr_ctrl && reg_wdata[amp_fault_pkg::CT_TRIG];
    infl_nxt   = wr_infl ? reg_wdata : infl_r;
    atten_nxt  = cond.overheat_warning_flag ? ctrl_r[amp_fault_pkg::CT_ATTEN_HI:amp_fault_pkg::CT_ATTEN_LO]
                          : amp_fault_pkg::ATTEN_NONE;
    rdata_nxt  = rdata_r;
    if (reg_rd)
    begin
      unique case (reg_addr)
        amp_fault_pkg::ADDR_STATUS:     rdata_nxt = status_r;
        amp_fault_pkg::ADDR_CONTROL:    rdata_nxt = ctrl_r;
        amp_fault_pkg::ADDR_INFLECTION: rdata_nxt = infl_r;
        default:                        rdata_nxt = amp_fault_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // Register bank flops; writes to the status address are ignored.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      status_r <= amp_fault_pkg::STATUS_RESET;
      ctrl_r   <= amp_fault_pkg::CONTROL_RESET;
      infl_r   <= amp_fault_pkg::INFLECTION_RESET;
      rdata_r  <= amp_fault_pkg::READ_UNMAPPED;
      trig_r   <= 1'b0;
      atten_r  <= amp_fault_pkg::ATTEN_NONE;
    end
    else
    begin
      status_r <= status_nxt;
      ctrl_r   <= ctrl_nxt;
      infl_r   <= infl_nxt;
      rdata_r  <= rdata_nxt;
      trig_r   <= trig_nxt;
      atten_r  <= atten_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Recovery sequencer.
  // ----------------------------------------------------------------------
  amp_fault_pkg::rec_state_type state_r;
  amp_fault_pkg::rec_state_type state_nxt;
  logic [amp_fault_pkg::KIND_W-1:0]  kind_r;
  logic [amp_fault_pkg::KIND_W-1:0]  kind_nxt;
  logic [amp_fault_pkg::KIND_W-1:0]  fault_now;
  logic [2:0]                        count_r;
  logic [2:0]                        count_nxt;
  logic [amp_fault_pkg::TIMER_W-1:0] timer_r;
  logic [amp_fault_pkg::TIMER_W-1:0] timer_nxt;
  logic                              enable_r;
  logic                              enable_nxt;
  logic                              manual_needed;
  logic                              exhausted;

  // A success needs a whole probation window without a fault, so a fault that
  // returns at once does not reset the attempt count and loop forever.
  always_comb
  begin
    fault_now = amp_fault_pkg::KIND_NONE;
    fault_now[amp_fault_pkg::CT_SEL_UV] = cond.uv;
    fault_now[amp_fault_pkg::CT_SEL_OT] = cond.overheat_fault_flag;
    fault_now[amp_fault_pkg::CT_SEL_OC] = cond.oc;
    manual_needed = |(kind_r & manual_sel);
    exhausted     = (limit_code != amp_fault_pkg::LIMIT_UNLIMITED) &&
                    (count_r >= amp_fault_pkg::attempts_allowed(limit_code));
    state_nxt = state_r;
    kind_nxt  = kind_r | fault_now;
    count_nxt = count_r;
    timer_nxt = amp_fault_pkg::TIMER_ZERO;
    unique case (state_r)
      amp_fault_pkg::ST_RUN:
      begin
        if (fault_now != amp_fault_pkg::KIND_NONE)
          state_nxt = amp_fault_pkg::ST_FAULT;
      end
      amp_fault_pkg::ST_FAULT:
      begin
        if (fault_now == amp_fault_pkg::KIND_NONE)
        begin
          if (manual_needed || exhausted)
            state_nxt = amp_fault_pkg::ST_LOCKED;
          else
          begin
            state_nxt = amp_fault_pkg::ST_CHECK;
            if (count_r != amp_fault_pkg::ATTEMPTS_SEVEN)
              count_nxt = count_r + amp_fault_pkg::COUNT_STEP;
          end
        end
      end
      amp_fault_pkg::ST_CHECK:
      begin
        if (fault_now != amp_fault_pkg::KIND_NONE)
          state_nxt = amp_fault_pkg::ST_FAULT;
        else if (timer_r == amp_fault_pkg::TIMER_LAST)
        begin
          state_nxt = amp_fault_pkg::ST_RUN;
          count_nxt = amp_fault_pkg::COUNT_ZERO;
          kind_nxt  = amp_fault_pkg::KIND_NONE;
        end
        else
          timer_nxt = timer_r + amp_fault_pkg::TIMER_STEP;
      end
      amp_fault_pkg::ST_LOCKED:
      begin
        if (trig_r)
        begin
          count_nxt = amp_fault_pkg::COUNT_ZERO;
          if (fault_now == amp_fault_pkg::KIND_NONE)
          begin
            state_nxt = amp_fault_pkg::ST_CHECK;
            kind_nxt  = amp_fault_pkg::KIND_NONE;
          end
        end
      end
    endcase
    enable_nxt = (state_nxt == amp_fault_pkg::ST_RUN) || (state_nxt == amp_fault_pkg::ST_CHECK);
  end

  // Sequencer flops; output stays off through reset.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r  <= amp_fault_pkg::ST_RUN;
      kind_r   <= amp_fault_pkg::KIND_NONE;
      count_r  <= amp_fault_pkg::COUNT_ZERO;
      timer_r  <= amp_fault_pkg::TIMER_ZERO;
      enable_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      kind_r   <= kind_nxt;
      count_r  <= count_nxt;
      timer_r  <= timer_nxt;
      enable_r <= enable_nxt;
    end
  end

  assign reg_rdata                   = rdata_r;
  assign amp_enable                  = enable_r;
  assign thermal_warning_attenuation = atten_r;
  assign supply_inflection_point     = infl_r;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence seq_fault_gone;
    (state_r == amp_fault_pkg::ST_FAULT) && (fault_now == amp_fault_pkg::KIND_NONE);
  endsequence

  sequence seq_trigger_clear;
    (state_r == amp_fault_pkg::ST_LOCKED) && trig_r && (fault_now == amp_fault_pkg::KIND_NONE);
  endsequence

  chk_status_read: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == amp_fault_pkg::ADDR_STATUS) |=>
      (reg_rdata == $past(status_r)) && !reg_rdata[amp_fault_pkg::ST_RSVD])
    else $error("status read mismatch or reserved bit set");

  chk_fault_flags: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 (status_r[amp_fault_pkg::ST_UV] == $past(cond.uv)) && (status_r[amp_fault_pkg::ST_OC] == $past(cond.oc))
      && (status_r[amp_fault_pkg::ST_OTF] == $past(cond.overheat_fault_flag)))
    else $error("fault status bits do not track conditions");

  chk_event_flags: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cond.clip) || $rose(cond.overheat_warning_flag) || $rose(cond.lim) |=>
      (status_r[amp_fault_pkg::ST_CLIP] == $past(cond.clip)) && (status_r[amp_fault_pkg::ST_OTW] == $past(cond.overheat_warning_flag))
      && (status_r[amp_fault_pkg::ST_LIM] || !$past(cond.lim)))
    else $error("event status bits lag their conditions");

  chk_battery_warn: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 status_r[amp_fault_pkg::ST_BAT] == ($past(battery_code) <= $past(infl_r)))
    else $error("battery warning compare wrong");

  chk_control_reset: assert property (@(posedge sys_clk)
    $fell(rst) |-> (ctrl_r == amp_fault_pkg::CONTROL_RESET) && (infl_r == amp_fault_pkg::INFLECTION_RESET))
    else $error("control or inflection reset value wrong");

  chk_atten_map: assert property (@(posedge sys_clk) disable iff (rst)
    cond.overheat_warning_flag ##1 cond.overheat_warning_flag |-> atten_r == $past(ctrl_r[amp_fault_pkg::CT_ATTEN_HI:amp_fault_pkg::CT_ATTEN_LO]))
    else $error("thermal attenuation not applied");

  chk_trigger_write: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == amp_fault_pkg::ADDR_CONTROL) |=> trig_r == $past(reg_wdata[amp_fault_pkg::CT_TRIG])
      && !ctrl_r[amp_fault_pkg::CT_TRIG])
    else $error("manual trigger write not handled");

  chk_attempt_limit: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == amp_fault_pkg::ST_CHECK) && ($past(state_r) == amp_fault_pkg::ST_FAULT)
      && (limit_code != amp_fault_pkg::LIMIT_UNLIMITED) |-> count_r <= amp_fault_pkg::attempts_allowed(limit_code))
    else $error("automatic attempts exceed the limit");

  chk_manual_select: assert property (@(posedge sys_clk) disable iff (rst)
    seq_fault_gone ##0 manual_needed |=> (state_r == amp_fault_pkg::ST_LOCKED) && !amp_enable)
    else $error("manual-recovery fault did not lock");

  chk_locked_off: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == amp_fault_pkg::ST_LOCKED) && !(trig_r && (fault_now == amp_fault_pkg::KIND_NONE)) |=> !amp_enable)
    else $error("output enabled while locked");

  chk_manual_attempt: assert property (@(posedge sys_clk) disable iff (rst)
    seq_trigger_clear |=> amp_enable && (count_r == amp_fault_pkg::COUNT_ZERO))
    else $error("manual attempt did not release output");

endmodule

// >>> tb/reg_host.sv
/*
  Host model for the register bank: one-cycle strobes with address and data.
  Assumes sys_clk from the bench and read data registered by the bank.
*/
`timescale 1ns/1ps
module reg_host
(
  input  wire logic       sys_clk,   // Register clock.
  input  wire logic [7:0] reg_rdata, // Read data.
  output logic      [7:0] reg_addr,  // Address.
  output logic      [7:0] reg_wdata, // Write data.
  output logic            reg_wr,    // Write strobe.
  output logic            reg_rd     // Read strobe.
);
  // ------
  // Bus cycles
  // ------
  // Idle values at time zero, so the bank never sees an unknown strobe.
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // A control write of bit 5 set is the only way a manual recovery attempt is requested.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Data is taken one edge late, since it holds until the next read anyway.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
  endtask
endmodule

// >>> tb/tb_amp_fault_status_recovery.sv
/*
  Self-checking bench for the fault status and recovery bank.
  Assumes the host model in reg_host.sv and the package constants.
*/
`timescale 1ns/1ps
module tb_amp_fault_status_recovery;
  logic       sys_clk;
  logic       rst;
  logic [5:0] raw;
  logic [7:0] battery;
  logic [7:0] addr, wdata, rdata, d, inf;
  logic       wr, rd, amp_enable;
  logic [1:0] att;
  int         error_cnt, n_compared, i;
  int         bitpos [6] = '{6, 3, 2, 1, 4, 5};
  int         rawidx [3] = '{1, 2, 0};

  // ------
  // Clock, host and device
  // ------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  reg_host HOST (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_addr(addr),
                 .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));

  amp_fault_status_recovery DUT (.sys_clk(sys_clk), .rst(rst), .uv_raw(raw[0]),
    .oc_raw(raw[1]), .otf_raw(raw[2]), .otw_raw(raw[3]), .clip_raw(raw[4]),
    .lim_raw(raw[5]), .battery_code(battery), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .amp_enable(amp_enable),
    .thermal_warning_attenuation(att), .supply_inflection_point(inf));

  // ------
  // Checking helpers
  // ------
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A bounded wait; running out of cycles ends the run.
  task automatic wait_amp(input logic v, input int n);
    for (int k = 0; k < n && amp_enable !== v; k++)
    begin
      @(posedge sys_clk);
      #1;
    end
    check("amp_enable", {7'h00, amp_enable}, {7'h00, v});
    if (amp_enable !== v)
      conclude();
  endtask

  // ------
  // Scenarios
  // ------
  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    raw = 6'h00;
    battery = 8'h40;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    wait_amp(1'b1, 5);
    HOST.rd(amp_fault_pkg::ADDR_STATUS, d);
    check("status", d, 8'h00);
    HOST.rd(amp_fault_pkg::ADDR_CONTROL, d);
    check("control", d, 8'h18);
    HOST.rd(amp_fault_pkg::ADDR_INFLECTION, d);
    check("inflection", d, 8'h22);
    check("inflection out", inf, 8'h22);
    HOST.wr(amp_fault_pkg::ADDR_STATUS, 8'hFF);
    HOST.rd(amp_fault_pkg::ADDR_STATUS, d);
    check("status", d, 8'h00);
    // Trigger bit must read back zero; attenuation follows the warning.
    HOST.wr(amp_fault_pkg::ADDR_CONTROL, 8'hBF);
    HOST.rd(amp_fault_pkg::ADDR_CONTROL, d);
    check("control", d, 8'h9F);
    raw[3] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("attenuation", {6'h00, att}, 8'h02);
    // Active attenuation also lights the gain reduction bit beside the warning.
    HOST.rd(amp_fault_pkg::ADDR_STATUS, d);
    check("status", d, 8'h22);
    raw <= 6'h00;
    HOST.wr(amp_fault_pkg::ADDR_CONTROL, 8'h18);
    repeat (8) @(posedge sys_clk);
    check("attenuation", {6'h00, att}, 8'h00);
    // Each condition alone lights its own status bit.
    for (i = 0; i < 6; i++)
    begin
      raw <= 6'(1 << i);
      repeat (8) @(posedge sys_clk);
      HOST.rd(amp_fault_pkg::ADDR_STATUS, d);
      check("status", d, 8'(1 << bitpos[i]));
    end
    raw <= 6'h00;
    wait_amp(1'b1, 1200);
    // The battery warning sets when the code equals the inflection point and clears one above it.
    battery <= 8'h22;
    repeat (8) @(posedge sys_clk);
    HOST.rd(amp_fault_pkg::ADDR_STATUS, d);
    check("status", d, 8'h01);
    battery <= 8'h23;
    repeat (3) @(posedge sys_clk);
    HOST.rd(amp_fault_pkg::ADDR_STATUS, d);
    check("status", d, 8'h00);
    // A new inflection point moves the warning threshold.
    HOST.wr(amp_fault_pkg::ADDR_INFLECTION, 8'h50);
    HOST.rd(amp_fault_pkg::ADDR_INFLECTION, d);
    check("inflection", d, 8'h50);
    check("inflection out", inf, 8'h50);
    HOST.rd(amp_fault_pkg::ADDR_STATUS, d);
    check("status", d, 8'h01);
    // Manual select per fault kind: stays off until the trigger.
    for (i = 0; i < 3; i++)
    begin
      HOST.wr(amp_fault_pkg::ADDR_CONTROL, 8'(8'h18 | (1 << i)));
      raw[rawidx[i]] <= 1'b1;
      wait_amp(1'b0, 20);
      raw <= 6'h00;
      repeat (50) @(posedge sys_clk);
      check("amp_enable", {7'h00, amp_enable}, 8'h00);
      HOST.wr(amp_fault_pkg::ADDR_CONTROL, 8'(8'h38 | (1 << i)));
      wait_amp(1'b1, 20);
      repeat (1100) @(posedge sys_clk);
    end
    // One automatic attempt allowed: a second fault locks the output off.
    HOST.wr(amp_fault_pkg::ADDR_CONTROL, 8'h00);
    raw[1] <= 1'b1;
    wait_amp(1'b0, 20);
    raw <= 6'h00;
    wait_amp(1'b1, 50);
    raw[1] <= 1'b1;
    wait_amp(1'b0, 20);
    raw <= 6'h00;
    repeat (50) @(posedge sys_clk);
    check("amp_enable", {7'h00, amp_enable}, 8'h00);
    HOST.wr(amp_fault_pkg::ADDR_CONTROL, 8'h20);
    wait_amp(1'b1, 20);
    conclude();
  end
endmodule
